// file: logic/sci_pkg.sv
// Constants, field layouts and carrier types of the serial interface
package sci_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] SCI_IDX_RATE   = 6'h10;
	localparam logic [5:0] SCI_IDX_CTL    = 6'h11;
	localparam logic [5:0] SCI_IDX_RXDATA = 6'h12;
	localparam logic [5:0] SCI_IDX_TXDATA = 6'h13;

	// Status/control field positions
	localparam int SCI_BIT_WAKE    = 0;
	localparam int SCI_BIT_XMIT_ON = 1;
	localparam int SCI_BIT_TX_IRQ  = 2;
	localparam int SCI_BIT_RCV_ON  = 3;
	localparam int SCI_BIT_RX_IRQ  = 4;
	localparam int SCI_BIT_TX_EMPT = 5;
	localparam int SCI_BIT_ERR     = 6;
	localparam int SCI_BIT_RX_FULL = 7;

	// Reset values
	localparam logic [3:0] SCI_RATE_RST  = 4'h0;
	localparam logic [7:0] SCI_CTL_RST   = 8'h20;

	// Clock source codes
	localparam logic [1:0] SCI_SRC_INT     = 2'h1;
	localparam logic [1:0] SCI_SRC_INT_OUT = 2'h2;
	localparam logic [1:0] SCI_SRC_EXT     = 2'h3;

	// Bit clock dividers of the bus clock, and sub-intervals per bit
	localparam int SCI_DIV_0   = 16;
	localparam int SCI_DIV_1   = 128;
	localparam int SCI_DIV_2   = 1024;
	localparam int SCI_DIV_3   = 4096;
	localparam int SCI_SUBBITS = 8;

	// Frame and line timing counts in bit times; sample point in sub-intervals
	localparam logic [3:0] SCI_PREAMBLE_BITS = 4'ha;
	localparam logic [3:0] SCI_FRAME_SAMPLES = 4'ha;
	localparam logic [3:0] SCI_IDLE_ONES     = 4'ha;
	localparam logic [3:0] SCI_TX_SHIFT_BITS = 4'h9;
	localparam logic [2:0] SCI_SAMPLE_PHASE  = 3'h3;

	// Rate and mode control byte
	typedef struct packed {
		logic       clk_src_hi;
		logic       clk_src_lo;
		logic       baud_sel_hi;
		logic       baud_sel_lo;
	} sci_rate_t;

	// Writable part of the control/status byte
	typedef struct packed {
		logic       rx_irq_on;
		logic       rcv_on;
		logic       tx_irq_on;
		logic       xmit_on;
		logic       wake_on_idle;
	} sci_ctl_t;

	// Timing strobes from the rate generator
	typedef struct packed {
		logic       sub_tick;
		logic       bit_tick;
		logic [2:0] phase;
	} sci_tick_t;

	typedef enum logic [3:0] {
		SCI_TX_OFF   = 4'b0001,
		SCI_TX_PRE   = 4'b0010,
		SCI_TX_IDLE  = 4'b0100,
		SCI_TX_SHIFT = 4'b1000
	} sci_tx_state_t;

	typedef enum logic [1:0] {
		SCI_RX_HUNT  = 2'b01,
		SCI_RX_FRAME = 2'b10
	} sci_rx_state_t;

endpackage : sci_pkg

// file: logic/sci_rate_gen.sv
// Bit-rate generator: internal divider or external 8x clock
`timescale 1ns/1ns
`default_nettype none
module sci_rate_gen
	import sci_pkg::*;
(
	input  wire logic      mclk,
	input  wire logic      srst,
	input  wire sci_rate_t rate,
	input  wire logic      ext_clk,
	output sci_tick_t      tick
);

	// Sub-interval period in bus clocks, less one, for a speed code
	function automatic logic [8:0] sub_period(input logic [1:0] sel);
		case (sel)
			2'h0:    sub_period = 9'((SCI_DIV_0 / SCI_SUBBITS) - 1);
			2'h1:    sub_period = 9'((SCI_DIV_1 / SCI_SUBBITS) - 1);
			2'h2:    sub_period = 9'((SCI_DIV_2 / SCI_SUBBITS) - 1);
			default: sub_period = 9'((SCI_DIV_3 / SCI_SUBBITS) - 1);
		endcase
	endfunction : sub_period

	logic [8:0] div_cnt;
	logic       ext_prev;
	logic [2:0] phase;

	wire logic       use_ext  = ({rate.clk_src_hi, rate.clk_src_lo} == SCI_SRC_EXT);
	wire logic [8:0] period   = sub_period({rate.baud_sel_hi, rate.baud_sel_lo});
	wire logic       int_tick = (div_cnt >= period); // [R02] [R20]
	wire logic       ext_tick = ext_clk & ~ext_prev; // [R04]
	wire logic       sub      = use_ext ? ext_tick : int_tick;

	// Divider and phase within the bit
	always_ff @(posedge mclk) begin
		if (srst) begin
			div_cnt  <= 9'h000;
			ext_prev <= 1'b0;
			phase    <= 3'h0;
		end else begin
			ext_prev <= ext_clk;
			div_cnt  <= (int_tick || use_ext) ? 9'h000 : div_cnt + 9'h001;
			if (sub) begin
				phase <= phase + 3'h1; // [R15]
			end
		end
	end

	assign tick.sub_tick = sub;
	assign tick.bit_tick = sub && (phase == 3'h7);
	assign tick.phase    = phase;

endmodule : sci_rate_gen
`default_nettype wire

// file: logic/sci_core.sv
// Asynchronous serial interface with a classic Wishbone register slave
// Summary of operation
// [R01] Clock source 10 drives bit clock out
// [R02] Internal bit clock at most bus clock/16
// [R03] Output clock 1x, rising edge mid-bit
// [R04] Source 11: external clock at 8x baud
// [R05] External clock stays at or below 1 MHz
// [R06] Software writes rate byte before control byte
// [R07] Serial pins serve while enables are set; tx_pin_oe stays set after xmit_on clears, until reset
// [R08] Transmit enable sends ten ones preamble first
// [R09] Empty transmit buffer leaves line idle high
// [R10] Written byte loads shifter, starts frame
// [R11] Frame: start zero, eight LSB-first, stop one
// [R12] Empty flag sets when byte moves to shifter
// [R13] Flag still set: keep sending ones only
// [R14] Receive enable turns on the receiver
// [R15] Each bit split into eight sub-intervals
// [R16] Ten centre samples; bad stop flags error
// [R17] Good stop stores byte, sets full flag
// [R18] Full flag still set means overrun error
// [R19] Status then data read clears receive flags
// [R20] Speed code picks divide 16/128/1024/4096
// [R21] Clock source code selects clock pin use; sclk_pin_oe keeps its value under codes 00 and 01
// [R22] Errors never overwrite the receive data
// [R23] Wake mode mutes receive flags until idle
// [R24] Interrupt from enabled receive or transmit flags
`timescale 1ns/1ns
`default_nettype none
module sci_core
	import sci_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        rx_pin,
	output logic             tx_pin_out,
	output logic             tx_pin_oe,
	input  wire logic        sclk_pin_in,
	output logic             sclk_pin_out,
	output logic             sclk_pin_oe,
	output logic             serial_irq
);

	sci_rate_t     rate_mode_ctl;
	sci_ctl_t      ctl;
	logic          tx_buf_empty;
	logic          rx_buf_full;
	logic          overrun_or_frame_err;
	logic [7:0]    tx_data;
	logic [7:0]    rx_data;
	logic          tx_arm;
	logic          rx_arm;
	logic          xmit_prev;
	sci_tx_state_t tx_state;
	logic [3:0]    tx_cnt;
	logic [8:0]    tx_sr;
	sci_rx_state_t rx_state;
	logic [2:0]    rx_sub;
	logic [3:0]    rx_cnt;
	logic [8:0]    rx_sr;
	logic [3:0]    idle_cnt;
	sci_tick_t     tick;

	sci_rate_gen u_rate (
		.mclk    (mclk),
		.srst    (srst),
		.rate    (rate_mode_ctl),
		.ext_clk (sclk_pin_in),
		.tick    (tick)
	);

	// Register index decode
	function automatic logic hit(input logic [7:0] adr, input logic [5:0] idx);
		hit = (adr[7:2] == idx) && (adr[1:0] == 2'h0);
	endfunction : hit

	wire logic       req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire logic       wr_lane  = req & wb_we_i & wb_sel_i[0];
	wire logic       rd       = req & ~wb_we_i;
	wire logic       wr_rate  = wr_lane & hit(wb_adr_i, SCI_IDX_RATE); // [R06]
	wire logic       wr_ctl   = wr_lane & hit(wb_adr_i, SCI_IDX_CTL);
	wire logic       wr_tx    = wr_lane & hit(wb_adr_i, SCI_IDX_TXDATA);
	wire logic       rd_ctl   = rd & hit(wb_adr_i, SCI_IDX_CTL);
	wire logic       rd_rx    = rd & hit(wb_adr_i, SCI_IDX_RXDATA);
	wire logic [7:0] stat     = {rx_buf_full, overrun_or_frame_err, tx_buf_empty,
		ctl.rx_irq_on, ctl.rcv_on, ctl.tx_irq_on, ctl.xmit_on, ctl.wake_on_idle};
	wire logic [7:0] rd_byte  = hit(wb_adr_i, SCI_IDX_CTL)    ? stat :
		hit(wb_adr_i, SCI_IDX_RXDATA) ? rx_data : 8'h00;
	wire logic [1:0] clk_src  = {rate_mode_ctl.clk_src_hi, rate_mode_ctl.clk_src_lo};

	// Transmitter events
	wire logic tx_start  = ~xmit_prev & ctl.xmit_on;
	wire logic tx_load   = tick.bit_tick && (tx_state == SCI_TX_IDLE) && !tx_buf_empty; // [R10]
	wire logic tx_clr    = wr_tx & tx_arm;

	// Receiver events: centre samples, tenth-sample outcome, flag clear, idle end
	wire logic rx_sample = (rx_state == SCI_RX_FRAME) && tick.sub_tick
		&& (rx_sub == SCI_SAMPLE_PHASE); // [R16]
	wire logic rx_last   = rx_sample && (rx_cnt == SCI_FRAME_SAMPLES - 4'h1);
	wire logic rx_live   = rx_last & ~ctl.wake_on_idle; // [R23]
	wire logic rx_good   = rx_live & rx_pin & ~rx_buf_full; // [R17]
	wire logic rx_bad    = rx_live & (~rx_pin | rx_buf_full); // [R16] [R18]
	wire logic rx_clr    = rd_rx & rx_arm; // [R19]
	wire logic idle_done = tick.bit_tick && rx_pin && (idle_cnt == SCI_IDLE_ONES - 4'h1);

	// Wishbone slave: one wait state, unmapped reads return zero
	always_ff @(posedge mclk) begin
		if (srst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			if (rd) begin
				wb_dat_o <= {24'h00_0000, rd_byte};
			end
		end
	end

	// Control registers written by software
	always_ff @(posedge mclk) begin
		if (srst) begin
			rate_mode_ctl <= SCI_RATE_RST;
			ctl           <= SCI_CTL_RST[4:0];
			tx_data       <= 8'h00;
		end else begin
			if (wr_rate) begin
				rate_mode_ctl <= wb_dat_i[3:0];
			end
			if (wr_ctl) begin
				ctl <= wb_dat_i[4:0];
			end else if (idle_done) begin
				ctl.wake_on_idle <= 1'b0; // [R23]
			end
			if (wr_tx) begin
				tx_data <= wb_dat_i[7:0];
			end
		end
	end

	// Status flags; hardware sets win over software clears
	always_ff @(posedge mclk) begin
		if (srst) begin
			tx_buf_empty         <= SCI_CTL_RST[SCI_BIT_TX_EMPT];
			rx_buf_full          <= SCI_CTL_RST[SCI_BIT_RX_FULL];
			overrun_or_frame_err <= SCI_CTL_RST[SCI_BIT_ERR];
			tx_arm               <= 1'b0;
			rx_arm               <= 1'b0;
		end else begin
			tx_buf_empty         <= tx_load | (tx_buf_empty & ~tx_clr); // [R12]
			rx_buf_full          <= rx_good | (rx_buf_full & ~rx_clr); // [R17] [R19]
			overrun_or_frame_err <= rx_bad | (overrun_or_frame_err & ~rx_clr); // [R22]
			if (rd_ctl && tx_buf_empty) begin
				tx_arm <= 1'b1;
			end else if (tx_clr) begin
				tx_arm <= 1'b0;
			end
			if (rd_ctl && (rx_buf_full || overrun_or_frame_err)) begin
				rx_arm <= 1'b1; // [R19]
			end else if (rx_clr) begin
				rx_arm <= 1'b0;
			end
		end
	end

	// Transmitter sequencing
	always_ff @(posedge mclk) begin
		if (srst) begin
			tx_state   <= SCI_TX_OFF;
			tx_cnt     <= 4'h0;
			tx_sr      <= 9'h1ff;
			tx_pin_out <= 1'b1;
			xmit_prev  <= 1'b0;
		end else begin
			xmit_prev <= ctl.xmit_on;
			case (tx_state)
				SCI_TX_OFF: begin
					tx_pin_out <= 1'b1;
					if (tx_start) begin
						tx_state <= SCI_TX_PRE;
						tx_cnt   <= SCI_PREAMBLE_BITS; // [R08]
					end
				end
				SCI_TX_PRE: begin
					tx_pin_out <= 1'b1;
					if (tick.bit_tick) begin
						tx_cnt <= tx_cnt - 4'h1;
						if (tx_cnt == 4'h1) begin
							tx_state <= SCI_TX_IDLE;
						end
					end
				end
				SCI_TX_IDLE: begin
					if (tx_load) begin
						tx_pin_out <= 1'b0; // [R11]
						tx_sr      <= {1'b1, tx_data}; // [R11]
						tx_cnt     <= SCI_TX_SHIFT_BITS;
						tx_state   <= SCI_TX_SHIFT;
					end else begin
						tx_pin_out <= 1'b1; // [R09] [R13]
					end
				end
				SCI_TX_SHIFT: begin
					if (tick.bit_tick) begin
						tx_pin_out <= tx_sr[0]; // [R11]
						tx_sr      <= {1'b1, tx_sr[8:1]};
						tx_cnt     <= tx_cnt - 4'h1;
						if (tx_cnt == 4'h1) begin
							tx_state <= SCI_TX_IDLE;
						end
					end
				end
				default: begin
					tx_state   <= SCI_TX_OFF;
					tx_pin_out <= 1'b1;
				end
			endcase
			if (!ctl.xmit_on) begin
				tx_state <= SCI_TX_OFF;
			end
		end
	end

	// Receiver: hunt for the first zero, then sample bit centres
	always_ff @(posedge mclk) begin
		if (srst) begin
			rx_state <= SCI_RX_HUNT;
			rx_sub   <= 3'h0;
			rx_cnt   <= 4'h0;
			rx_sr    <= 9'h000;
			rx_data  <= 8'h00;
		end else begin
			case (rx_state)
				SCI_RX_HUNT: begin
					if (ctl.rcv_on && tick.sub_tick && !rx_pin) begin // [R14] [R15]
						rx_state <= SCI_RX_FRAME;
						rx_sub   <= 3'h0;
						rx_cnt   <= 4'h0;
					end
				end
				SCI_RX_FRAME: begin
					if (tick.sub_tick) begin
						rx_sub <= rx_sub + 3'h1;
					end
					if (rx_sample) begin
						rx_sr  <= {rx_pin, rx_sr[8:1]};
						rx_cnt <= rx_cnt + 4'h1;
					end
					if (rx_last || !ctl.rcv_on) begin
						rx_state <= SCI_RX_HUNT;
					end
				end
				default: rx_state <= SCI_RX_HUNT;
			endcase
			if (rx_good) begin
				rx_data <= rx_sr[8:1]; // [R17] [R22]
			end
		end
	end

	// Idle-line counter ending wake-up mode
	always_ff @(posedge mclk) begin
		if (srst) begin
			idle_cnt <= 4'h0;
		end else if (!ctl.wake_on_idle || (tick.bit_tick && !rx_pin)) begin
			idle_cnt <= 4'h0;
		end else if (tick.bit_tick) begin
			idle_cnt <= idle_cnt + 4'h1; // [R23]
		end
	end

	// Pin drivers, clock output and interrupt request
	always_ff @(posedge mclk) begin
		if (srst) begin
			tx_pin_oe    <= 1'b0;
			sclk_pin_oe  <= 1'b0;
			sclk_pin_out <= 1'b0;
			serial_irq   <= 1'b0;
		end else begin
			if (ctl.xmit_on) begin
				tx_pin_oe <= 1'b1; // [R07] [R08]
			end
			if (rate_mode_ctl.clk_src_hi) begin
				sclk_pin_oe <= ~rate_mode_ctl.clk_src_lo; // [R21]
			end
			sclk_pin_out <= (clk_src == SCI_SRC_INT_OUT) & tick.phase[2]; // [R03] [R21]
			serial_irq   <= (ctl.rx_irq_on & (rx_buf_full | overrun_or_frame_err))
				| (ctl.tx_irq_on & tx_buf_empty); // [R24]
		end
	end

endmodule : sci_core
`default_nettype wire

// file: dv/sci_monitor.sv
// Bus and serial-line checker for the serial core
`timescale 1ns/1ns
`default_nettype none
module sci_monitor (
	input wire logic        mclk,
	input wire logic        srst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic        tx_pin_out,
	input wire logic        tx_pin_oe,
	input wire logic        sclk_pin_out,
	input wire logic        sclk_pin_oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	// Request taken, then a one-cycle answer
	sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
	property p_ack; s_req |=> s_ans; endproperty
	property p_dat; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
	property p_pre; $rose(tx_pin_oe) |-> tx_pin_out [*8]; endproperty
	property p_oe; tx_pin_oe |=> tx_pin_oe; endproperty
	property p_off; !tx_pin_oe |-> tx_pin_out; endproperty
	property p_start; $fell(tx_pin_out) |-> !tx_pin_out [*8]; endproperty
	property p_half; $rose(sclk_pin_out) |-> sclk_pin_out [*8]; endproperty
	property p_ckoe; sclk_pin_out |-> sclk_pin_oe; endproperty
	a_ack: assert property (p_ack) else $error("ack not a single pulse");
	a_dat: assert property (p_dat) else $error("read data upper bits set");
	a_pre: assert property (p_pre) else $error("preamble not ones");
	a_oe: assert property (p_oe) else $error("tx pin enable dropped");
	a_off: assert property (p_off) else $error("line low while off");
	a_start: assert property (p_start) else $error("short low bit");
	a_half: assert property (p_half) else $error("bit clock too fast");
	a_ckoe: assert property (p_ckoe) else $error("clock out undriven");
endmodule : sci_monitor
bind sci_core sci_monitor sci_monitor_inst (.mclk(mclk), .srst(srst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .tx_pin_out(tx_pin_out),
	.tx_pin_oe(tx_pin_oe), .sclk_pin_out(sclk_pin_out), .sclk_pin_oe(sclk_pin_oe));
`default_nettype wire

// file: dv/sci_station.sv
// Remote serial station on the line
`timescale 1ns/1ns
`default_nettype none
module sci_station #(
	parameter int BIT = 16
) (
	input wire logic mclk,
	input wire logic tx_line,
	output logic     rx_line
);
	initial rx_line = 1'b1;
	// Start zero, LSB first, chosen stop level, one idle bit
	task automatic send(input logic [7:0] d, input logic stop);
		logic [10:0] f;
		f = {1'b1, stop, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rx_line <= f[i];
			repeat (BIT) @(posedge mclk);
		end
	endtask : send
	// Mid-bit capture of eight data bits and the stop bit
	task automatic grab(output logic [8:0] q);
		while (tx_line !== 1'b0) @(posedge mclk);
		repeat (BIT / 2) @(posedge mclk);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT) @(posedge mclk);
			q[i] = tx_line;
		end
	endtask : grab
endmodule : sci_station
`default_nettype wire

// file: dv/test_sci_core.sv
// Self-checking bench for the serial core
`timescale 1ns/1ns
`default_nettype none
module test_sci_core
	import sci_pkg::*;
;
	logic        mclk = 1'b0;
	logic        srst = 1'b1;
	logic        cyc  = 1'b0;
	logic        stb  = 1'b0;
	logic        we   = 1'b0;
	logic [7:0]  adr  = 8'h00;
	logic [31:0] dat  = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o, rx_pin, tx_pin_out, tx_pin_oe;
	logic        sclk_pin_out, sclk_pin_oe, serial_irq;
	logic        ext_run = 1'b0;
	logic        ext_clk = 1'b0;
	int          ext_cnt = 0;
	logic [7:0]  q;
	logic [8:0]  fr;
	int          n_fail = 0;
	int          checks = 0;
	int          divs[4] = '{SCI_DIV_0, SCI_DIV_1, SCI_DIV_2, SCI_DIV_3};
	time         t0;

	// Bus clock
	always #25 mclk = ~mclk;

	sci_core sci_core_inst (.mclk(mclk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .rx_pin(rx_pin), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
		.sclk_pin_in(ext_clk), .sclk_pin_out(sclk_pin_out), .sclk_pin_oe(sclk_pin_oe),
		.serial_irq(serial_irq));
	sci_station sci_station_inst (.mclk(mclk), .tx_line(tx_pin_out), .rx_line(rx_pin));

	// External 8x clock at 1 MHz: toggles every ten bus clocks
	always @(posedge mclk) begin
		if (ext_run) begin
			if (ext_cnt == 9) begin
				ext_cnt <= 0;
				ext_clk <= ~ext_clk;
			end else begin
				ext_cnt <= ext_cnt + 1;
			end
		end
	end

	// Compare and count
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Classic single cycle, held until ack is sampled
	task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= {idx, 2'b00};
		dat <= {24'h0, d};
		@(posedge mclk);
		while (wb_ack_o !== 1'b1) @(posedge mclk);
		q = wb_dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus

	task automatic rd(input logic [5:0] idx, input logic [7:0] e, input string nm);
		bus(1'b0, idx, 8'h00);
		chk(nm, {8'h00, e}, {8'h00, q});
	endtask : rd

	// Count cycles with the line low
	task automatic count_low(input int n, input string nm);
		int c = 0;
		repeat (n) begin
			@(posedge mclk);
			if (tx_pin_out !== 1'b1) c++;
		end
		chk(nm, 16'h0, 16'(c));
	endtask : count_low

	task automatic sclk_up();
		while (sclk_pin_out !== 1'b0) @(posedge mclk);
		while (sclk_pin_out !== 1'b1) @(posedge mclk);
	endtask : sclk_up

	task automatic print_verdict();
		$display("Checks %0d failures %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict

	// Watchdog
	initial begin
		repeat (80000) @(posedge mclk);
		n_fail++;
		print_verdict();
	end

	// Main sequence
	initial begin
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		rd(SCI_IDX_CTL, SCI_CTL_RST, "reset status");
		rd(SCI_IDX_RATE, 8'h00, "rate read");
		rd(6'h3f, 8'h00, "unmapped read");
		bus(1'b1, SCI_IDX_RATE, 8'h08);
		bus(1'b1, SCI_IDX_CTL, 8'h0a);
		@(posedge mclk);
		chk("clock pin enable", 16'h1, {15'h0, sclk_pin_oe});
		chk("tx pin enable", 16'h1, {15'h0, tx_pin_oe});
		count_low(150, "preamble");
		for (int i = 0; i < 2; i++) begin
			rd(SCI_IDX_CTL, 8'h2a, "status empty");
			bus(1'b1, SCI_IDX_TXDATA, 8'ha5 ^ i[7:0]);
			sci_station_inst.grab(fr);
			chk("tx frame", {7'h1, 8'ha5 ^ i[7:0]}, {7'h0, fr});
		end
		count_low(48, "idle line");
		sci_station_inst.send(8'h3c, 1'b1);
		rd(SCI_IDX_CTL, 8'haa, "status full");
		bus(1'b1, SCI_IDX_CTL, 8'h1a);
		repeat (2) @(posedge mclk);
		chk("irq", 16'h1, {15'h0, serial_irq});
		bus(1'b1, SCI_IDX_CTL, 8'h0a);
		rd(SCI_IDX_RXDATA, 8'h3c, "rx data");
		rd(SCI_IDX_CTL, 8'h2a, "status cleared");
		sci_station_inst.send(8'h11, 1'b1);
		sci_station_inst.send(8'h22, 1'b1);
		rd(SCI_IDX_CTL, 8'hea, "status overrun");
		rd(SCI_IDX_RXDATA, 8'h11, "kept data");
		rd(SCI_IDX_CTL, 8'h2a, "status cleared");
		sci_station_inst.send(8'h33, 1'b0);
		rd(SCI_IDX_CTL, 8'h6a, "status framing");
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, SCI_IDX_RATE, 8'h08 | i[7:0]);
			sclk_up();
			sclk_up();
			t0 = $time;
			sclk_up();
			chk("clock period", divs[i][15:0], 16'(($time - t0) / 50));
		end
		// External 8x clock: start bit lasts eight external periods
		bus(1'b1, SCI_IDX_RATE, 8'h0c);
		ext_run <= 1'b1;
		bus(1'b0, SCI_IDX_CTL, 8'h00);
		chk("ext clock pin enable", 16'h0, {15'h0, sclk_pin_oe});
		chk("ext clock out", 16'h0, {15'h0, sclk_pin_out});
		bus(1'b1, SCI_IDX_TXDATA, 8'hff);
		while (tx_pin_out !== 1'b0) @(posedge mclk);
		t0 = $time;
		while (tx_pin_out === 1'b0) @(posedge mclk);
		chk("ext start bit", 16'd160, 16'(($time - t0) / 50));
		print_verdict();
	end
endmodule : test_sci_core
`default_nettype wire
